// [include/nvc_pkg.sv]
/*
 Constants and carrier types for the host-side controller of a nonvolatile SRAM.
 Assumes a 25 MHz system clock and an asynchronous memory part on plain pins.
*/
package nvc_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CLK_NS = 40;
   // Access timing (ns) and derived cycle counts
   localparam int T_ACCESS_NS   = 80;
   localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_WRITE_NS    = 80;
   localparam int WRITE_CYC     = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_TURN_NS     = 40;
   localparam int TURN_CYC      = (T_TURN_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_STORE_REQ_NS = 120;
   localparam int STORE_REQ_CYC  = (T_STORE_REQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   // Reset values of the memory pins (all inactive)
   localparam logic PIN_IDLE = 1'b1;

   typedef enum logic [2:0] {
      NVC_IDLE  = 3'b000,
      NVC_READ  = 3'b001,
      NVC_WRITE = 3'b010,
      NVC_TURN  = 3'b011,
      NVC_SREQ  = 3'b100,
      NVC_SWAIT = 3'b101
   } nvc_state_t;

   // User request towards the controller
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              upper_n;
      logic              lower_n;
   } nvc_req_t;

   // Control pins towards the memory part
   typedef struct packed {
      logic chip_sel_n;
      logic out_drive_n;
      logic write_strobe_n;
      logic upper_byte_sel_n;
      logic lower_byte_sel_n;
   } nvc_ctl_t;
endpackage : nvc_pkg

// [rtl/nvc_sync.sv]
/*
 Two-flip-flop synchroniser for one level from outside the clock domain.
 Assumes the input is a pin; only the second stage is used downstream.
*/
module nvc_sync (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic din,
   output logic      dout
);
   logic meta_reg;

   // Two stages, both reset to the pin's idle high level
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= 1'b1;
         dout     <= 1'b1;
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule : nvc_sync

// [rtl/nvc_host.sv]
/*
 Host-side controller that drives a nonvolatile SRAM over its asynchronous pins:
 reads, byte-lane writes and hardware store requests via the shared busy pin.
 Assumes the part is wired directly to the pins and that the busy pin has a pull-up.
*/
// Contract
// - Host holds address stable through write
// - Host keeps drive high during write
// - No capacitor: host disables power-loss save; this controller has no control for it
// - Write strobe inactive after power-on recall
module nvc_host
   import nvc_pkg::*;
(
   input  wire logic                      clock,
   input  wire logic                      rst_b,
   input  wire nvc_pkg::nvc_req_t         req,
   input  wire logic                      req_valid,
   output logic                           req_ready,
   output logic [nvc_pkg::DATA_W-1:0]     rdata,
   output logic                           rdata_valid,
   input  wire logic                      store_request,
   output logic                           store_done,
   output logic                           mem_busy,
   output logic                           write_pending,
   output nvc_pkg::nvc_ctl_t              mem_ctl,
   output logic [nvc_pkg::ADDR_W-1:0]     mem_addr,
   input  wire logic [nvc_pkg::DATA_W-1:0] dq_in,
   output logic [nvc_pkg::DATA_W-1:0]     dq_out,
   output logic                           dq_oe,
   input  wire logic                      store_busy_n_in,
   output logic                           store_busy_n_out,
   output logic                           store_busy_n_oe
);
   import nvc_pkg::*;

   nvc_state_t        state_reg, state_next;
   logic [CNT_W-1:0]  cnt_reg, cnt_next;
   nvc_ctl_t          ctl_reg, ctl_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next;
   logic [DATA_W-1:0] rdata_next;
   logic              oe_reg, oe_next;
   logic              busy_drv_reg, busy_drv_next;
   logic              pend_reg, pend_next;
   logic              done_next;
   logic              rvalid_next;
   logic              busy_sync;

   // Count cycles truncated to the counter width
   function automatic logic [CNT_W-1:0] to_cnt(input int cyc);
      to_cnt = cyc[CNT_W-1:0];
   endfunction : to_cnt

   // Busy pin comes from outside: two flops before any use
   nvc_sync u_busy_sync (
      .clock (clock),
      .rst_b (rst_b),
      .din   (store_busy_n_in),
      .dout  (busy_sync)
   );

   // Pin low from any source means store, recall or external hold
   wire part_busy  = !busy_sync;
   wire cnt_done   = (cnt_reg == CNT_ZERO);
   wire idle       = (state_reg == NVC_IDLE);
   wire can_access = idle && !part_busy && !busy_drv_reg;
   wire take_req   = req_valid && can_access;
   wire take_store = store_request && can_access && !req_valid;
   wire read_lanes_ok = !(req.upper_n && req.lower_n);

   assign req_ready = can_access;

   // Sequencing of access and store request cycles
   always_comb begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      ctl_next      = ctl_reg;
      addr_next     = addr_reg;
      wdata_next    = wdata_reg;
      rdata_next    = rdata;
      oe_next       = oe_reg;
      busy_drv_next = busy_drv_reg;
      pend_next     = pend_reg;
      done_next     = 1'b0;
      rvalid_next   = 1'b0;
      case (state_reg)
         NVC_IDLE: begin
            if (take_req) begin
               addr_next                 = req.addr;
               ctl_next.chip_sel_n       = 1'b0;
               ctl_next.upper_byte_sel_n = req.upper_n;
               ctl_next.lower_byte_sel_n = req.lower_n;
               if (req.write) begin
                  wdata_next              = req.wdata;
                  oe_next                 = 1'b1;
                  ctl_next.out_drive_n    = 1'b1;
                  ctl_next.write_strobe_n = 1'b0;
                  cnt_next   = to_cnt(WRITE_CYC);
                  state_next = NVC_WRITE;
               end else begin
                  ctl_next.out_drive_n    = !read_lanes_ok;
                  ctl_next.write_strobe_n = 1'b1;
                  cnt_next   = to_cnt(ACCESS_CYC);
                  state_next = NVC_READ;
               end
            end else if (take_store) begin
               busy_drv_next = 1'b1;
               cnt_next      = to_cnt(STORE_REQ_CYC);
               state_next    = NVC_SREQ;
            end
         end
         NVC_READ: begin
            if (cnt_done) begin
               rdata_next  = dq_in;
               rvalid_next = 1'b1;
               ctl_next    = '{default: PIN_IDLE};
               cnt_next    = to_cnt(TURN_CYC);
               state_next  = NVC_TURN;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         NVC_WRITE: begin
            if (cnt_done) begin
               // Strobe rises alone; select, lanes and address hold a cycle longer
               ctl_next.write_strobe_n = 1'b1;
               pend_next  = 1'b1;
               cnt_next   = to_cnt(TURN_CYC);
               state_next = NVC_TURN;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         NVC_TURN: begin
            oe_next  = 1'b0;
            ctl_next = '{default: PIN_IDLE};
            if (cnt_done) state_next = NVC_IDLE;
            else cnt_next = cnt_reg - 4'h1;
         end
         NVC_SREQ: begin
            if (cnt_done) begin
               busy_drv_next = 1'b0;
               state_next    = NVC_SWAIT;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         NVC_SWAIT: begin
            if (!part_busy) begin
               pend_next  = 1'b0;
               done_next  = 1'b1;
               state_next = NVC_IDLE;
            end
         end
         default: state_next = NVC_IDLE;
      endcase
   end

   // State and pin registers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= NVC_IDLE;
         cnt_reg      <= CNT_ZERO;
         ctl_reg      <= '{default: PIN_IDLE};
         addr_reg     <= '0;
         wdata_reg    <= '0;
         rdata        <= '0;
         oe_reg       <= 1'b0;
         busy_drv_reg <= 1'b0;
         pend_reg     <= 1'b0;
         store_done   <= 1'b0;
         rdata_valid  <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         ctl_reg      <= ctl_next;
         addr_reg     <= addr_next;
         wdata_reg    <= wdata_next;
         rdata        <= rdata_next;
         oe_reg       <= oe_next;
         busy_drv_reg <= busy_drv_next;
         pend_reg     <= pend_next;
         store_done   <= done_next;
         rdata_valid  <= rvalid_next;
      end
   end

   // Pin outputs; busy pin is open drain, only ever pulled low
   assign mem_ctl          = ctl_reg;
   assign mem_addr         = addr_reg;
   assign dq_out           = wdata_reg;
   assign dq_oe            = oe_reg;
   assign store_busy_n_out = 1'b0;
   assign store_busy_n_oe  = busy_drv_reg;
   assign mem_busy         = part_busy;
   assign write_pending    = pend_reg;
endmodule : nvc_host

// [test/nvc_mem_model.sv]
/* Behavioural memory part on the far side of the host controller.
   Assumes the bench resolves the open-drain busy pin with a pull-up. */
module nvc_mem_model
   import nvc_pkg::*;
#(parameter int GRACE_NS = 90, parameter int STORE_NS = 400)
(
   input  wire nvc_pkg::nvc_ctl_t          ctl,
   input  wire logic [nvc_pkg::ADDR_W-1:0] addr,
   input  wire logic [nvc_pkg::DATA_W-1:0] din,
   input  wire logic                       pin,
   output logic [nvc_pkg::DATA_W-1:0]      dout,
   output logic                            pull_low
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] mem [0:2**ADDR_W-1];
   logic [DATA_W-1:0] junk = 16'h5a5a;
   logic              pend;
   // Access decode, blocked while the pin is low
   wire rd = !ctl.chip_sel_n && !ctl.out_drive_n && ctl.write_strobe_n && pin;
   wire wr = !ctl.chip_sel_n && !ctl.write_strobe_n && pin;
   // Released lanes show a toggling pattern
   always #20 junk = ~junk;
   assign dout[15:8] = rd && !ctl.upper_byte_sel_n ? mem[addr][15:8] : junk[15:8];
   assign dout[7:0]  = rd && !ctl.lower_byte_sel_n ? mem[addr][7:0] : junk[7:0];
   // Capture at the end of the write cycle
   always @(negedge wr) begin
      if (!ctl.upper_byte_sel_n) mem[addr][15:8] = din[15:8];
      if (!ctl.lower_byte_sel_n) mem[addr][7:0] = din[7:0];
      pend = 1'b1;
   end
   // Power-up recall, then stores on a low pin after a write; pin edges kept off rising clock edges
   initial begin
      pull_low = 1'b1;
      #310 pend = 1'b0;
      pull_low = 1'b0;
      forever begin
         @(negedge pin);
         if (pend) begin
            #(GRACE_NS) pull_low = 1'b1;
            #(STORE_NS) pend = 1'b0;
            pull_low = 1'b0;
         end
      end
   end
endmodule : nvc_mem_model

// [test/nvc_host_checker.sv]
/* Port assertions for the host controller.
   Assumes one clock domain and is bound into every instance. */
module nvc_host_checker
   import nvc_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_b,
   input wire nvc_pkg::nvc_req_t req,
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire logic              rdata_valid,
   input wire logic              store_request,
   input wire logic              store_done,
   input wire logic              mem_busy,
   input wire logic              write_pending,
   input wire nvc_pkg::nvc_ctl_t mem_ctl,
   input wire logic [nvc_pkg::ADDR_W-1:0] mem_addr,
   input wire logic              store_busy_n_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   read_ctl_a: assert property (!mem_ctl.out_drive_n |-> !mem_ctl.chip_sel_n && mem_ctl.write_strobe_n)
      else $error("drive low outside a read");
   write_ctl_a: assert property (!mem_ctl.write_strobe_n |-> !mem_ctl.chip_sel_n && mem_ctl.out_drive_n)
      else $error("strobe low without select or with drive");
   busy_block_a: assert property (mem_busy |-> !req_ready)
      else $error("request accepted while part busy");
   read_answer_a: assert property (req_valid && req_ready && !req.write |-> ##4 rdata_valid)
      else $error("read data late");
   pend_set_a: assert property ($rose(mem_ctl.write_strobe_n) |-> write_pending)
      else $error("write end without pending flag");
   pend_clear_a: assert property (store_done |=> !write_pending)
      else $error("pending flag kept after store");
   pulse_len_a: assert property ($rose(store_busy_n_oe) |-> store_busy_n_oe[*4] ##1 !store_busy_n_oe)
      else $error("busy pulse length wrong");
   store_take_a: assert property ($rose(store_busy_n_oe) |-> $past(store_request) && !$past(req_valid))
      else $error("busy pin pulled without store request");
   done_pin_a: assert property (store_done |-> !mem_busy)
      else $error("store done while pin low");
   addr_hold_a: assert property (!mem_ctl.write_strobe_n |=> $stable(mem_addr)
      && $stable(mem_ctl.upper_byte_sel_n) && $stable(mem_ctl.lower_byte_sel_n))
      else $error("address or lanes moved at write end");
endmodule : nvc_host_checker
bind nvc_host nvc_host_checker u_chk (.clock(clock), .rst_b(rst_b), .req(req),
   .req_valid(req_valid), .req_ready(req_ready), .rdata_valid(rdata_valid),
   .store_request(store_request), .store_done(store_done), .mem_busy(mem_busy),
   .write_pending(write_pending), .mem_ctl(mem_ctl), .mem_addr(mem_addr),
   .store_busy_n_oe(store_busy_n_oe));

// [test/testbench.sv]
/* Self-checking bench: host controller against a behavioural memory part.
   Assumes the busy pin pull-up is the pin wire's idle level. */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import nvc_pkg::*;
   logic              clock = 1'b0;
   logic              rst_b = 1'b0;
   nvc_req_t          req = '0;
   logic              req_valid = 1'b0;
   logic              store_request = 1'b0;
   logic              req_ready, rdata_valid, store_done, mem_busy, write_pending;
   logic              dq_oe, sb_out, sb_oe, pull_low;
   logic [DATA_W-1:0] rdata, dq_in, dq_out;
   logic [ADDR_W-1:0] mem_addr;
   nvc_ctl_t          mem_ctl;
   int                num_errors = 0;
   int                checks_done = 0;
   int                cyc = 0;
   // Open-drain pin and released data lines
   wire pin = !((sb_oe && !sb_out) || pull_low);
   wire [DATA_W-1:0] wd = dq_oe ? dq_out : ~dq_out;
   always #20 clock = ~clock;
   nvc_host u_dut (.clock(clock), .rst_b(rst_b), .req(req), .req_valid(req_valid),
      .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
      .store_request(store_request), .store_done(store_done), .mem_busy(mem_busy),
      .write_pending(write_pending), .mem_ctl(mem_ctl), .mem_addr(mem_addr), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .store_busy_n_in(pin), .store_busy_n_out(sb_out),
      .store_busy_n_oe(sb_oe));
   nvc_mem_model u_mem (.ctl(mem_ctl), .addr(mem_addr), .din(wd), .pin(pin), .dout(dq_in),
      .pull_low(pull_low));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic tick;
      @(posedge clock);
      #1;
   endtask : tick
   task automatic wait_idle;
      while (req_ready !== 1'b1) tick();
   endtask : wait_idle
   // One request, held until taken
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [1:0] ln);
      wait_idle();
      req = {w, a, d, ln};
      req_valid = 1'b1;
      tick();
      req_valid = 1'b0;
   endtask : xfer
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] ln,
                     output logic [DATA_W-1:0] v);
      int n = 0;
      xfer(1'b0, a, 16'h0000, ln);
      while (rdata_valid !== 1'b1 && n++ < 20) tick();
      v = rdata;
   endtask : rd
   // Recall hold, then full words at both address ends
   task automatic t_words;
      logic [DATA_W-1:0] v;
      repeat (3) tick();
      chk("recall busy", mem_busy, 1'b1);
      chk("recall ready", req_ready, 1'b0);
      xfer(1'b1, 18'h00000, 16'h1234, 2'b00);
      xfer(1'b1, 18'h3ffff, 16'hbeef, 2'b00);
      rd(18'h00000, 2'b00, v);
      chk("word lo", v, 16'h1234);
      rd(18'h3ffff, 2'b00, v);
      chk("word hi", v, 16'hbeef);
   endtask : t_words
   // Single-lane writes keep the other lane
   task automatic t_lanes;
      logic [DATA_W-1:0] v;
      xfer(1'b1, 18'h00000, 16'haa55, 2'b01);
      xfer(1'b1, 18'h3ffff, 16'h0077, 2'b10);
      rd(18'h00000, 2'b01, v);
      chk("upper lane", v[15:8], 8'haa);
      rd(18'h00000, 2'b10, v);
      chk("kept lane", v[7:0], 8'h34);
   endtask : t_lanes
   // Store request; busy length shows whether the part stored
   task automatic t_store(input logic pend_exp, input logic long_exp);
      logic [DATA_W-1:0] v;
      int n = 0;
      int busy = 0;
      chk("pend before", write_pending, pend_exp);
      wait_idle();
      store_request = 1'b1;
      tick();
      store_request = 1'b0;
      while (store_done !== 1'b1 && n++ < 100) begin
         busy += (mem_busy === 1'b1);
         tick();
      end
      chk("done", store_done, 1'b1);
      tick();
      chk("pend cleared", write_pending, 1'b0);
      chk("long busy", busy > 8, long_exp);
      rd(18'h3ffff, 2'b00, v);
      chk("kept word", v, 16'hbe77);
   endtask : t_store
   // Cycle ceiling
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (4) @(posedge clock);
      #1 rst_b = 1'b1;
      t_words();
      t_lanes();
      t_store(1'b1, 1'b1);
      t_store(1'b0, 1'b0);
      complete_run();
   end
endmodule : testbench
